// ===== design/paf_defines.svh
// constants for the packet address filter
`ifndef PAF_DEFINES_SVH
`define PAF_DEFINES_SVH
`define PAF_ADDR_W          32
`define PAF_AUTO_REPLY_RST  8'h07
`define PAF_AUTO_REPLY_EN   0
`define PAF_MODE_RST        8'h07
`define PAF_MODE_ACK_BIT    4
`define PAF_MODE_FIELD_LO   0
`define PAF_MODE_FIELD_HI   2
`define PAF_MODE_SERIAL     3'h0
`define PAF_MODE_USER       3'h6
`define PAF_MODE_EXT        3'h7
`define PAF_MASK_RST        32'hFFFF_FFFF
`endif

// ===== design/paf_pkg.sv
// types shared by the packet address filter
`default_nettype none
package paf_pkg;
  typedef enum logic [1:0] {PAF_SERIAL, PAF_USER, PAF_EXT} paf_mode_t;
endpackage
`default_nettype wire

// ===== design/paf_skid.sv
// two-entry buffer with valid/ready on both sides
`default_nettype none
module paf_skid #(
  parameter int W = 64
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [2];   // storage
  logic [W-1:0] mem_next [2];
  logic         wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0]   cnt_reg, cnt_next;   // occupancy
  logic         push, pop;

  // next-state: ready only while a slot is free, so a stall backs up the source
  always_comb
  begin
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push)
    begin
      mem_next[wp_reg] = in_data;
      wp_next = ~wp_reg;
    end
    if (pop)
      rp_next = ~rp_reg;
    cnt_next = cnt_reg + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end
    else
    begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end

  assign in_ready  = (cnt_reg != 2'd2);
  assign out_valid = (cnt_reg != 2'd0);
  assign out_data  = mem_reg[rp_reg];
endmodule
`default_nettype wire

// ===== design/paf_match.sv
// masked address acceptance check
`default_nettype none
`include "paf_defines.svh"
module paf_match (
  input  wire logic [`PAF_ADDR_W-1:0] dest,
  input  wire logic [`PAF_ADDR_W-1:0] local_addr,
  input  wire logic [`PAF_ADDR_W-1:0] mask,
  output logic                        hit
);
  // exact hit, or broadcast: unmasked bits equal and masked bits all ones
  always_comb
  begin
    hit = (dest == local_addr) ||
          (((dest ^ local_addr) & ~mask) == '0 && (dest & mask) == mask);
  end
endmodule
`default_nettype wire

// ===== design/paf_top.sv
// packet address filter: stamps outgoing addresses, filters incoming packets
`default_nettype none
`include "paf_defines.svh"
// How it works
// - stamp tx source/destination per current mode
// - mode changes apply to next packet
// - receive checks all addressing types
// - forward matches to host, drop rest
// - mode bit enables acknowledged delivery
// - three modes; user and extended share the local source address
// - extended mode uses destination/local id bytes
// - mask splits address into fields
// - auto reply setting resets to 0x07
// - auto reply copies source into destination
// - host reads back last transmitter address
// - broadcast is local OR mask
module paf_top (
  input  wire logic                   clk,
  input  wire logic                   reset,
  // settings from the command interface
  input  wire logic                   cfg_mode_we,              // write addressing_mode_select
  input  wire logic [7:0]             cfg_mode_data,
  input  wire logic                   cfg_auto_we,              // write auto_reply_addressing
  input  wire logic [7:0]             cfg_auto_data,
  input  wire logic                   cfg_dest_we,              // write destination_id_bytes
  input  wire logic [31:0]            cfg_dest_data,
  input  wire logic                   cfg_mask_we,              // write user_id_field_mask
  input  wire logic [31:0]            cfg_mask_data,
  input  wire logic                   cfg_broadcast_we,         // load destination = local OR mask
  input  wire logic [31:0]            local_source_id_bytes,    // extended/user local address
  input  wire logic [31:0]            serial_number_addressing, // factory serial address
  input  wire logic [31:0]            serial_dest_id,           // serial-mode destination
  input  wire logic [31:0]            user_dest_id,             // user-mode destination
  output logic [7:0]                  addressing_mode_select,
  output logic [7:0]                  auto_reply_addressing,
  output logic [31:0]                 destination_id_bytes,     // readback
  output logic [31:0]                 user_id_field_mask,
  // transmit stamping
  input  wire logic                   tx_req,                   // packet start pulse
  output logic                        tx_stamp_valid,
  output logic [31:0]                 tx_src,
  output logic [31:0]                 tx_dst,
  output logic                        tx_ack_req,
  // receive headers from the radio
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  input  wire logic [31:0]            rx_src,
  input  wire logic [31:0]            rx_dst,
  // accepted packets toward the host port
  output logic                        host_valid,
  input  wire logic                   host_ready,
  output logic [63:0]                 host_data,
  output logic                        rx_drop                   // pulse on silent drop
);
  // setting registers, all readable by the host
  logic [7:0]         mode_reg;          // addressing mode and ack enable
  logic [7:0]         mode_next;
  logic [7:0]         auto_reg;          // auto reply setting
  logic [7:0]         auto_next;
  logic [31:0]        dest_reg;          // destination id for extended stamping
  logic [31:0]        dest_next;
  logic [31:0]        mask_reg;          // field mask for broadcast decode
  logic [31:0]        mask_next;
  // transmit stamp registers; fields held until the next request, valid a one-cycle pulse
  logic               stv_reg;           // stamp valid pulse
  logic               stv_next;
  logic [31:0]        tsrc_reg;          // stamped source
  logic [31:0]        tsrc_next;
  logic [31:0]        tdst_reg;          // stamped destination
  logic [31:0]        tdst_next;
  logic               tack_reg;          // stamped ack request
  logic               tack_next;
  // receive side
  logic               drop_reg;          // silent drop pulse
  logic               drop_next;
  // per-type compares, all evaluated on every header
  logic               hit_ext;           // masked or exact match on local address
  logic               hit_user;          // exact match on local address
  logic               hit_ser;           // match on the serial address
  logic               accept;            // any addressing type matched
  logic               buf_ready;         // buffer has a free slot
  logic               take;              // header handed over at this edge
  logic               copy_src;          // reception rewrites the destination
  logic               ack_en;            // ack enable bit of the mode
  logic               auto_en;           // auto reply enable bit
  paf_pkg::paf_mode_t cur_mode;          // decoded mode

  // decode mode field; unknown codes fall back to extended, the mode a
  // joined unit runs in, so a stray code still leaves a usable link
  // only the low field picks the address set; higher bits are options
  always_comb
  begin
    case (mode_reg[`PAF_MODE_FIELD_HI:`PAF_MODE_FIELD_LO])
      `PAF_MODE_SERIAL: cur_mode = paf_pkg::PAF_SERIAL;
      `PAF_MODE_USER:   cur_mode = paf_pkg::PAF_USER;
      `PAF_MODE_EXT:    cur_mode = paf_pkg::PAF_EXT;
      default:          cur_mode = paf_pkg::PAF_EXT;
    endcase
  end

  // single option bits, named once so the next-state logic reads plainly
  assign ack_en  = mode_reg[`PAF_MODE_ACK_BIT];
  assign auto_en = auto_reg[`PAF_AUTO_REPLY_EN];

  // receive check covers every type regardless of own mode
  // masked compare: exact local hit or broadcast inside our fields
  paf_match u_ext (
    .dest       (rx_dst),
    .local_addr (local_source_id_bytes),
    .mask       (mask_reg),
    .hit        (hit_ext)
  );

  // exact and serial compares; the own transmit mode plays no part here
  // the exact compare overlaps the masked one, kept for a clear trace
  always_comb
  begin
    hit_user = (rx_dst == local_source_id_bytes);
    hit_ser  = (rx_dst == serial_number_addressing);
    accept   = hit_ext || hit_ser || hit_user;
  end

  // handshake toward the radio; rejected headers also wait for a free
  // slot, so headers leave the radio strictly in order
  always_comb
  begin
    rx_ready = buf_ready;                              // stall when host port is full
    take     = rx_valid && rx_ready;
    copy_src = take && accept && auto_en;
  end

  // settings next state: host writes, broadcast load and the sender copy
  always_comb
  begin
    mode_next = mode_reg;
    auto_next = auto_reg;
    dest_next = dest_reg;
    mask_next = mask_reg;
    // mode writes take effect on the next packet, no restart needed
    if (cfg_mode_we)
    begin
      mode_next = cfg_mode_data;
    end
    // auto reply may be switched off so a host-set destination sticks
    if (cfg_auto_we)
    begin
      auto_next = cfg_auto_data;
    end
    if (cfg_mask_we)
    begin
      mask_next = cfg_mask_data;
    end
    // a plain host write of the destination
    if (cfg_dest_we)
    begin
      dest_next = cfg_dest_data;
    end
    // broadcast uses the mask held now, not one written in the same cycle
    if (cfg_broadcast_we)
    begin
      dest_next = local_source_id_bytes | mask_reg;
    end
    // reception wins so readback names the last sender
    if (copy_src)
    begin
      dest_next = rx_src;
    end
  end

  // settings registers; reset gives extended mode with auto reply on
  // a host write in the reset cycle is lost, the host must wait one edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_reg <= `PAF_MODE_RST;
      auto_reg <= `PAF_AUTO_REPLY_RST;
      dest_reg <= '0;
      mask_reg <= `PAF_MASK_RST;
    end
    else
    begin
      mode_reg <= mode_next;
      auto_reg <= auto_next;
      dest_reg <= dest_next;
      mask_reg <= mask_next;
    end
  end

  // stamp next state: fields load only on a request and then hold, so the
  // framer may read them at any time before the next packet
  // limitation: user and extended modes share the one local source port
  always_comb
  begin
    stv_next  = tx_req;
    tsrc_next = tsrc_reg;
    tdst_next = tdst_reg;
    tack_next = tack_reg;
    if (tx_req)
    begin
      tack_next = ack_en;
      case (cur_mode)
        paf_pkg::PAF_SERIAL:
        begin
          // factory serial address as source
          tsrc_next = serial_number_addressing;
          tdst_next = serial_dest_id;
        end
        paf_pkg::PAF_USER:
        begin
          // user address set
          tsrc_next = local_source_id_bytes;
          tdst_next = user_dest_id;
        end
        paf_pkg::PAF_EXT:
        begin
          // destination register, possibly the last sender
          tsrc_next = local_source_id_bytes;
          tdst_next = dest_reg;
        end
        default:
        begin
          // not reached from the decode; treated as extended
          tsrc_next = local_source_id_bytes;
          tdst_next = dest_reg;
        end
      endcase
    end
  end

  // stamp registers; the valid pulse lasts exactly one cycle per request
  // the fields keep their value so a late reader still sees the packet
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stv_reg  <= 1'b0;
      tsrc_reg <= '0;
      tdst_reg <= '0;
      tack_reg <= 1'b0;
    end
    else
    begin
      stv_reg  <= stv_next;
      tsrc_reg <= tsrc_next;
      tdst_reg <= tdst_next;
      tack_reg <= tack_next;
    end
  end

  // drop next state: a taken header that matched nothing leaves no trace
  // but this pulse; it never reaches the buffer
  always_comb
  begin
    drop_next = take && !accept;
  end

  // drop register; one pulse per rejected header
  // registered so the pulse is glitch free for a counter outside
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      drop_reg <= 1'b0;
    end
    else
    begin
      drop_reg <= drop_next;
    end
  end

  // accepted headers buffered so a host stall loses none; source sits in
  // the upper half of the word, destination in the lower half
  // two entries keep full rate while the host answers ready a cycle late
  paf_skid #(
    .W (64)
  ) u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (rx_valid && accept),
    .in_ready  (buf_ready),
    .in_data   ({rx_src, rx_dst}),
    .out_valid (host_valid),
    .out_ready (host_ready),
    .out_data  (host_data)
  );

  // settings readback straight from the registers
  assign addressing_mode_select = mode_reg;
  assign auto_reply_addressing  = auto_reg;
  assign destination_id_bytes   = dest_reg;
  assign user_id_field_mask     = mask_reg;
  // stamp outputs straight from the registers
  assign tx_stamp_valid         = stv_reg;
  assign tx_src                 = tsrc_reg;
  assign tx_dst                 = tdst_reg;
  assign tx_ack_req             = tack_reg;
  // drop pulse
  assign rx_drop                = drop_reg;
endmodule
`default_nettype wire

// ===== verif/paf_sva.sv
// concurrent checks on the packet address filter ports
`default_nettype none
module paf_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cfg_broadcast_we,
  input wire logic [31:0] local_source_id_bytes,
  input wire logic [31:0] serial_number_addressing,
  input wire logic [7:0]  addressing_mode_select,
  input wire logic [7:0]  auto_reply_addressing,
  input wire logic [31:0] destination_id_bytes,
  input wire logic [31:0] user_id_field_mask,
  input wire logic        tx_req,
  input wire logic        tx_stamp_valid,
  input wire logic [31:0] tx_src,
  input wire logic [31:0] tx_dst,
  input wire logic        tx_ack_req,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [31:0] rx_src,
  input wire logic [31:0] rx_dst,
  input wire logic        host_valid,
  input wire logic        host_ready,
  input wire logic [63:0] host_data,
  input wire logic        rx_drop
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic take;  // header taken at this edge
  logic hit;   // taken header aimed exactly at us
  assign take = rx_valid && rx_ready;
  assign hit  = take && (rx_dst == local_source_id_bytes);
  a_tx_stamp_pulse: assert property (tx_req |=> tx_stamp_valid)
    else $error("no stamp after tx request");
  a_ack_from_mode: assert property (tx_req |=> tx_ack_req == $past(addressing_mode_select[4]))
    else $error("ack request does not follow mode");
  a_ext_stamp: assert property (tx_req && addressing_mode_select[2:0] == 3'h7 |=>
    tx_src == $past(local_source_id_bytes) && tx_dst == $past(destination_id_bytes))
    else $error("extended stamp wrong");
  a_serial_src: assert property (tx_req && addressing_mode_select[2:0] == 3'h0 |=>
    tx_src == $past(serial_number_addressing))
    else $error("serial source wrong");
  a_exact_forward: assert property (hit |=> host_valid && !rx_drop)
    else $error("matching packet not forwarded");
  a_auto_copy: assert property (hit && auto_reply_addressing[0] |=> destination_id_bytes == $past(rx_src))
    else $error("sender address not copied");
  a_drop_cause: assert property (rx_drop |-> $past(take) && !$past(hit))
    else $error("drop without rejected take");
  a_host_hold: assert property (host_valid && !host_ready |=> host_valid && $stable(host_data))
    else $error("host word lost while stalled");
  // a sender copy in the same cycle wins over the broadcast load
  a_bcast_load: assert property (cfg_broadcast_we && !(take && auto_reply_addressing[0]) |=>
    destination_id_bytes == ($past(local_source_id_bytes) | $past(user_id_field_mask)))
    else $error("broadcast destination wrong");
  c_hit: cover property (hit);
  c_drop: cover property (rx_drop);
  c_full: cover property (rx_valid && !rx_ready);
endmodule
bind paf_top paf_sva u_paf_sva (.*);
`default_nettype wire

// ===== verif/paf_host_model.sv
// host port sink that can stall and keeps what it takes
`default_nettype none
module paf_host_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        host_valid,
  input  wire logic [63:0] host_data,
  output logic             host_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] got [$];  // words taken, oldest first
  initial host_ready = 1'b0;
  // ready moves off the sampling edge so takes never race
  always @(negedge clk) host_ready <= !stall;
  // a word counts only on the edge that hands it over
  always @(posedge clk) if (host_valid && host_ready) got.push_back(host_data);
endmodule
`default_nettype wire

// ===== verif/paf_top_tb.sv
// self-checking bench for the packet address filter
`default_nettype none
module paf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] LOC = 32'h1234_5600;  // local address
  localparam logic [31:0] MSK = 32'h0000_00FF;  // node field mask
  logic clk, reset, cfg_mode_we, cfg_auto_we, cfg_dest_we, cfg_mask_we, cfg_broadcast_we, stall;
  logic tx_req, tx_stamp_valid, tx_ack_req, rx_valid, rx_ready, host_valid, host_ready, rx_drop;
  logic [7:0]  cfg_mode_data, cfg_auto_data, addressing_mode_select, auto_reply_addressing;
  logic [31:0] cfg_dest_data, cfg_mask_data, local_source_id_bytes, serial_number_addressing;
  logic [31:0] serial_dest_id, user_dest_id, destination_id_bytes, user_id_field_mask;
  logic [31:0] tx_src, tx_dst, rx_src, rx_dst;
  logic [63:0] host_data;
  int          fail_count, check_count, drops;
  paf_top u_paf_top (.*);
  paf_host_model u_paf_host_model (.*);
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // silent drops seen at the port
  always @(posedge clk) if (rx_drop === 1'b1) drops++;
  // wide enough for the stamp word: valid, ack, source and destination
  task automatic chk(input logic [95:0] g, e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one setting write: k picks mode, auto, dest, mask, broadcast
  task automatic wr(input int k, input logic [31:0] v);
    @(negedge clk);
    {cfg_mode_we, cfg_auto_we, cfg_dest_we, cfg_mask_we, cfg_broadcast_we} = 5'b1_0000 >> k;
    {cfg_mode_data, cfg_auto_data, cfg_dest_data, cfg_mask_data} = {v[7:0], v[7:0], v, v};
    @(negedge clk);
    {cfg_mode_we, cfg_auto_we, cfg_dest_we, cfg_mask_we, cfg_broadcast_we} = 5'h0;
  endtask
  task automatic tx(input logic [31:0] s, d, input logic a);
    @(negedge clk);
    tx_req = 1;
    @(negedge clk);
    tx_req = 0;
    chk({tx_stamp_valid, tx_ack_req, tx_src, tx_dst}, {1'b1, a, s, d});
  endtask
  // header held until the edge that takes it
  task automatic rx(input logic [31:0] s, d);
    @(negedge clk);
    {rx_valid, rx_src, rx_dst} = {1'b1, s, d};
    while (!rx_ready) @(negedge clk);
    @(negedge clk);
    rx_valid = 0;
  endtask
  task automatic drain(input int n);
    for (int i = 0; i < 40 && u_paf_host_model.got.size() < n; i++) @(negedge clk);
    chk(u_paf_host_model.got.size(), n);
  endtask
  task automatic t_stamp;
    chk({addressing_mode_select, auto_reply_addressing, user_id_field_mask}, 48'h0707_FFFF_FFFF);
    wr(3, MSK);
    wr(4, 0);
    chk(destination_id_bytes, LOC | MSK);
    wr(0, 8'h17);
    tx(LOC, LOC | MSK, 1);
    wr(0, 8'h06);
    tx(LOC, user_dest_id, 0);
    wr(0, 8'h00);
    tx(serial_number_addressing, serial_dest_id, 0);
    $display("stamp test done");
  endtask
  task automatic t_filter;
    rx(32'hAAAA_0001, LOC);
    chk(destination_id_bytes, 32'hAAAA_0001);
    rx(32'hAAAA_0002, LOC | MSK);
    rx(32'hAAAA_0003, LOC ^ 32'h0000_0100);
    rx(32'hAAAA_0004, serial_number_addressing);
    drain(3);
    chk(u_paf_host_model.got[1], {32'hAAAA_0002, LOC | MSK});
    chk({drops, destination_id_bytes}, {32'd1, 32'hAAAA_0004});
    $display("filter test done");
  endtask
  // host-written destination, then auto reply off keeps it past a reception
  task automatic t_auto;
    wr(2, 32'h0D0E_0005);
    chk(destination_id_bytes, 32'h0D0E_0005);
    wr(1, 8'h00);
    chk(auto_reply_addressing, 8'h00);
    rx(32'hCCCC_0001, LOC);
    chk(destination_id_bytes, 32'h0D0E_0005);
    wr(1, 8'h07);
    wr(0, 8'h07);
    tx(LOC, 32'h0D0E_0005, 0);
    $display("auto reply test done");
  endtask
  task automatic t_stall;
    u_paf_host_model.got.delete();
    stall = 1;
    rx(32'hBBBB_0001, LOC);
    rx(32'hBBBB_0002, LOC);
    chk(rx_ready, 0);
    fork rx(32'hBBBB_0003, LOC); join_none
    repeat (5) @(negedge clk);
    chk(u_paf_host_model.got.size(), 0);
    stall = 0;
    drain(3);
    chk(u_paf_host_model.got[2], {32'hBBBB_0003, LOC});
    $display("stall test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // the tests need well under 300 cycles (15 us); 100 us leaves room for a slow stall
  initial
  begin
    #100us;
    fail_count++;
    $display("Error at %0t: timeout", $time);
    wrap_up();
  end
  initial
  begin
    {reset, stall, tx_req, rx_valid, rx_src, rx_dst} = {3'b100, 65'h0};
    {cfg_mode_we, cfg_auto_we, cfg_dest_we, cfg_mask_we, cfg_broadcast_we} = 5'h0;
    {cfg_mode_data, cfg_auto_data, cfg_dest_data, cfg_mask_data} = 80'h0;
    {local_source_id_bytes, serial_number_addressing} = {LOC, 32'hA5A5_0001};
    {serial_dest_id, user_dest_id} = {32'h5E00_0002, 32'h00C0_0003};
    repeat (6) @(posedge clk);
    @(negedge clk);
    reset = 0;
    t_stamp();
    t_filter();
    t_auto();
    t_stall();
    wrap_up();
  end
endmodule
`default_nettype wire
